// ==== rtl/irq_route_defines.svh ====
`ifndef IRQ_ROUTE_DEFINES_SVH
`define IRQ_ROUTE_DEFINES_SVH
// Summary of operation
// R01 - writing the deferred-service set bit makes that exception pending until serviced
// R02 - writing the deferred-service clear bit removes its pending state
// R03 - deferred-service exception is always enabled; only its priority is set
// R04 - deferred-service priority field of handler priority reg 3: 0-3 small, 0-7 large
// R05 - each core has a 24-bit down-counting system tick timer
// R06 - tick counter reaching zero raises the tick exception when enabled
// R07 - zero count raises the tick exception only while timer irq enable is set
// R08 - tick priority field of handler priority reg 3: 0-3 small, 0-7 large
// R09 - writing the tick pending set bit makes the tick exception pending anytime
// R10 - writing the tick pending clear bit clears a pending tick exception
// R11 - all 147 peripheral lines go one-to-one to large core lines 0-146
// R12 - each of 32 small core lines is driven by its selected peripheral source
// R13 - a peripheral line is the OR of that peripheral's conditions
// R14 - peripheral lines are levels held until the handler clears the peripheral
// R15 - only lines 0 to 40 can wake from deep sleep
// R16 - only small core lines 0 to 7 can wake that core
// R17 - software should put wake-capable sources on small core lines 0 to 7
// R18 - lines 0-14 are port interrupts 0-14, line 15 the combined port interrupt
// R19 - lines 16-24 carry supply detect through radio, in fixed order
// R20 - lines 25-32 are the eight inter-processor interrupts, all wake-capable
// R21 - non-maskable exception may be taken from any of the 147 sources
// R22 - lines 41 and 42 are serial blocks 0 and 1, active mode only
// R23 - a per-core register selects the source of its non-maskable exception
// R24 - each small core selector holds an 8-bit index and passes the level unchanged
`define NUM_SRC 147
`define NUM_SMALL_LINES 32
`define SMALL_WAKE_LINES 8
`define WAKE_SRC_LAST 8'd40
`define LINE_IPC_FIRST 25
`define LINE_IPC_LAST 32
`define TICK_W 24
`define PRIO_W 3
`define SEL_W 8
`define REG_CTRL_STATE 5'h00
`define REG_PRIO3 5'h04
`define REG_TICK_CSR 5'h08
`define REG_TICK_RELOAD 5'h0c
`define REG_TICK_CURRENT 5'h10
`define REG_NMI_SEL 5'h14
`define REG_LINE_SEL_REGION 3'h2
`define DEFER_SET_BIT 28
`define DEFER_CLR_BIT 27
`define TICK_SET_BIT 26
`define TICK_CLR_BIT 25
`define PRIO_DEFER_LSB 16
`define PRIO_TICK_LSB 24
`define CSR_EN_BIT 0
`define CSR_INT_BIT 1
`define CSR_FLAG_BIT 16
`define RST_PRIO 3'h0
`define RST_TICK 24'h000000
`define RST_SEL 8'h00
`endif

// ==== rtl/irq_route_pkg.sv ====
package irq_route_pkg;
    typedef struct packed {
        logic defer_pend;
        logic tick_pend;
        logic [2:0] defer_prio;
        logic [2:0] tick_prio;
        logic tick_en;
        logic tick_int;
        logic tick_flag;
        logic [23:0] reload;
        logic [23:0] current;
        logic [7:0] nmi_sel;
    } core_state_t;

    typedef struct packed {
        core_state_t [1:0] core;
        logic [31:0][7:0] line_sel;
        logic [146:0] large_irq;
        logic [31:0] small_irq;
        logic [1:0] nmi;
        logic small_wake;
        logic large_wake;
        logic ack;
        logic [31:0] dat;
    } route_state_t;
endpackage

// ==== rtl/irq_route_top.sv ====
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`include "irq_route_defines.svh"

module irq_route_top
    import irq_route_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [146:0] periph_irq_i,
    input wire logic [1:0] defer_done_i,
    input wire logic [1:0] tick_done_i,
    output logic [146:0] large_core_irq_o,
    output logic [31:0] small_core_irq_o,
    output logic [1:0] nmi_o,
    output logic [1:0] defer_pend_o,
    output logic [1:0] tick_pend_o,
    output logic [5:0] defer_prio_o,
    output logic [5:0] tick_prio_o,
    output logic small_wake_o,
    output logic large_wake_o
);

    route_state_t st;
    route_state_t next_st;
    logic req;
    logic wr;
    logic rd;
    logic [1:0] hit;
    logic [1:0] w_ctl;
    logic [1:0] w_pri;
    logic [1:0] w_csr;
    logic [1:0] r_csr;
    logic [1:0] w_rld;
    logic [1:0] w_cur;
    logic [1:0] w_nmi;
    logic [1:0] tick_hw;
    logic line_hit;
    logic [31:0] rdat;
    logic [7:0] s;
    int c;
    int k;
    int b;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    assign req = cyc_i & stb_i & ~st.ack;
    assign wr = req & we_i;
    assign rd = req & ~we_i;
    assign line_hit = req & (adr_i[7:5] == `REG_LINE_SEL_REGION);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            hit[i] = req & (adr_i[7:6] == 2'b00) & (adr_i[5] == i[0]);
            w_ctl[i] = wr & hit[i] & (adr_i[4:0] == `REG_CTRL_STATE) & sel_i[3];
            w_pri[i] = wr & hit[i] & (adr_i[4:0] == `REG_PRIO3);
            w_csr[i] = wr & hit[i] & (adr_i[4:0] == `REG_TICK_CSR) & sel_i[0];
            r_csr[i] = rd & hit[i] & (adr_i[4:0] == `REG_TICK_CSR);
            w_rld[i] = wr & hit[i] & (adr_i[4:0] == `REG_TICK_RELOAD);
            w_cur[i] = wr & hit[i] & (adr_i[4:0] == `REG_TICK_CURRENT);
            w_nmi[i] = wr & hit[i] & (adr_i[4:0] == `REG_NMI_SEL) & sel_i[0];
            tick_hw[i] = st.core[i].tick_en & st.core[i].tick_int
                & (st.core[i].current == 24'h000001); // R06 R07
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux

    always_comb begin
        rdat = 32'h00000000;
        if (line_hit) begin
            rdat = st.line_sel[adr_i[4:2]*4 +: 4];
        end
        for (int i = 0; i < 2; i++) begin
            if (hit[i]) begin
                unique case (adr_i[4:0])
                    `REG_CTRL_STATE: begin
                        rdat[`DEFER_SET_BIT] = st.core[i].defer_pend;
                        rdat[`TICK_SET_BIT] = st.core[i].tick_pend;
                    end
                    `REG_PRIO3: begin
                        rdat[`PRIO_DEFER_LSB +: 3] = st.core[i].defer_prio;
                        rdat[`PRIO_TICK_LSB +: 3] = st.core[i].tick_prio;
                    end
                    `REG_TICK_CSR: begin
                        rdat[`CSR_EN_BIT] = st.core[i].tick_en;
                        rdat[`CSR_INT_BIT] = st.core[i].tick_int;
                        rdat[`CSR_FLAG_BIT] = st.core[i].tick_flag;
                    end
                    `REG_TICK_RELOAD: rdat[23:0] = st.core[i].reload;
                    `REG_TICK_CURRENT: rdat[23:0] = st.core[i].current;
                    `REG_NMI_SEL: rdat[7:0] = st.core[i].nmi_sel;
                    default: rdat = 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        s = 8'h00;
        next_st.ack = req;
        if (rd) begin
            next_st.dat = rdat;
        end else begin
            next_st.dat = 32'h00000000;
        end
        for (c = 0; c < 2; c++) begin
            // pending flags: set wins over clear and service
            next_st.core[c].defer_pend = (st.core[c].defer_pend
                & ~(w_ctl[c] & dat_i[`DEFER_CLR_BIT]) // R02
                & ~defer_done_i[c])
                | (w_ctl[c] & dat_i[`DEFER_SET_BIT]); // R01 R03
            next_st.core[c].tick_pend = (st.core[c].tick_pend
                & ~(w_ctl[c] & dat_i[`TICK_CLR_BIT]) // R10
                & ~tick_done_i[c])
                | (w_ctl[c] & dat_i[`TICK_SET_BIT]) // R09
                | tick_hw[c]; // R06 R07
            // priority fields, small core limited to 0-3
            if (w_pri[c] & sel_i[2]) begin
                next_st.core[c].defer_prio = dat_i[`PRIO_DEFER_LSB +: 3]; // R04
                if (c == 0) begin
                    next_st.core[c].defer_prio[2] = 1'b0; // R04
                end
            end
            if (w_pri[c] & sel_i[3]) begin
                next_st.core[c].tick_prio = dat_i[`PRIO_TICK_LSB +: 3]; // R08
                if (c == 0) begin
                    next_st.core[c].tick_prio[2] = 1'b0; // R08
                end
            end
            if (w_csr[c]) begin
                next_st.core[c].tick_en = dat_i[`CSR_EN_BIT];
                next_st.core[c].tick_int = dat_i[`CSR_INT_BIT]; // R07
            end
            for (b = 0; b < 3; b++) begin
                if (w_rld[c] & sel_i[b]) begin
                    next_st.core[c].reload[b*8 +: 8] = dat_i[b*8 +: 8];
                end
            end
            // down-counter, reload after zero
            if (st.core[c].tick_en) begin
                if (st.core[c].current == `RST_TICK) begin
                    next_st.core[c].current = st.core[c].reload; // R05
                end else begin
                    next_st.core[c].current = st.core[c].current - 24'h000001; // R05
                end
            end
            if (w_cur[c]) begin
                next_st.core[c].current = `RST_TICK;
            end
            // count flag clears on read or current write, wrap wins
            next_st.core[c].tick_flag = (st.core[c].tick_flag & ~r_csr[c] & ~w_cur[c])
                | (st.core[c].tick_en & (st.core[c].current == 24'h000001));
            if (w_nmi[c]) begin
                next_st.core[c].nmi_sel = dat_i[7:0]; // R23
            end
            s = st.core[c].nmi_sel;
            next_st.nmi[c] = (s < 8'd147) ? periph_irq_i[s] : 1'b0; // R21
        end
        for (k = 0; k < 4; k++) begin
            if (line_hit & we_i & sel_i[k]) begin
                next_st.line_sel[{adr_i[4:2], k[1:0]}] = dat_i[k*8 +: 8]; // R24
            end
        end
        next_st.large_irq = periph_irq_i; // R11 R13 R14 R18 R19 R22
        next_st.small_wake = 1'b0;
        for (k = 0; k < `NUM_SMALL_LINES; k++) begin
            s = st.line_sel[k];
            next_st.small_irq[k] = (s < 8'd147) ? periph_irq_i[s] : 1'b0; // R12 R24
            if (k < `SMALL_WAKE_LINES) begin
                next_st.small_wake = next_st.small_wake
                    | (next_st.small_irq[k] & (s <= `WAKE_SRC_LAST)); // R16
            end
        end
        next_st.large_wake = |periph_irq_i[40:0]; // R15 R20
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            for (int i = 0; i < 2; i++) begin
                st.core[i].defer_prio <= `RST_PRIO;
                st.core[i].tick_prio <= `RST_PRIO;
                st.core[i].reload <= `RST_TICK;
                st.core[i].current <= `RST_TICK;
                st.core[i].nmi_sel <= `RST_SEL;
            end
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign dat_o = st.dat;
    assign ack_o = st.ack;
    assign large_core_irq_o = st.large_irq;
    assign small_core_irq_o = st.small_irq;
    assign nmi_o = st.nmi;
    assign small_wake_o = st.small_wake;
    assign large_wake_o = st.large_wake;
    assign defer_pend_o = {st.core[1].defer_pend, st.core[0].defer_pend};
    assign tick_pend_o = {st.core[1].tick_pend, st.core[0].tick_pend};
    assign defer_prio_o = {st.core[1].defer_prio, st.core[0].defer_prio};
    assign tick_prio_o = {st.core[1].tick_prio, st.core[0].tick_prio};

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wrap0;
        st.core[0].tick_en && !w_cur[0] && st.core[0].current == 24'h000001;
    endsequence

    sequence s_reload0;
        st.core[0].current == 24'h000000 ##1 st.core[0].current == $past(st.core[0].reload);
    endsequence

    a_defer_set: assert property ( // R01
        w_ctl[0] && dat_i[`DEFER_SET_BIT] |=> defer_pend_o[0]
    ) else $error("deferred set write did not make it pending");

    a_defer_hold: assert property ( // R03
        defer_pend_o[1] && !w_ctl[1] && !defer_done_i[1] |=> defer_pend_o[1]
    ) else $error("deferred pending lost without clear");

    a_defer_clear: assert property ( // R02
        w_ctl[1] && dat_i[`DEFER_CLR_BIT] && !dat_i[`DEFER_SET_BIT] |=> !defer_pend_o[1]
    ) else $error("deferred clear write ignored");

    a_prio_small: assert property ( // R04
        defer_prio_o[2] == 1'b0 && tick_prio_o[2] == 1'b0
    ) else $error("small core priority above three");

    a_prio_large: assert property ( // R08
        w_pri[1] && sel_i[3] |=> tick_prio_o[5:3] == $past(dat_i[`PRIO_TICK_LSB +: 3])
    ) else $error("large core tick priority not stored");

    a_tick_count: assert property ( // R05
        st.core[0].tick_en && !w_cur[0] && st.core[0].current > 24'h000001
        |=> st.core[0].current == $past(st.core[0].current) - 24'h000001
    ) else $error("tick counter did not decrement");

    a_tick_reload: assert property ( // R05
        s_wrap0 |=> s_reload0
    ) else $error("tick counter did not reload after zero");

    a_tick_raise: assert property ( // R06
        s_wrap0 and st.core[0].tick_int |=> tick_pend_o[0]
    ) else $error("tick exception not raised at zero");

    a_tick_gate: assert property ( // R07
        $rose(tick_pend_o[0]) |-> $past(tick_hw[0])
            || $past(w_ctl[0] && dat_i[`TICK_SET_BIT])
    ) else $error("tick pending without cause");

    a_tick_soft: assert property ( // R09
        w_ctl[1] && dat_i[`TICK_SET_BIT] |=> tick_pend_o[1]
    ) else $error("tick set write ignored");

    a_tick_clear: assert property ( // R10
        w_ctl[0] && dat_i[`TICK_CLR_BIT] && !dat_i[`TICK_SET_BIT] && !tick_hw[0]
        |=> !tick_pend_o[0]
    ) else $error("tick clear write ignored");

    a_large_pass: assert property ( // R11
        ##1 large_core_irq_o == $past(periph_irq_i)
    ) else $error("large core line differs from source");

    a_small_route: assert property ( // R12
        ##1 small_core_irq_o[3] == ($past(st.line_sel[3]) < 8'd147
            && $past(periph_irq_i[st.line_sel[3]]))
    ) else $error("small core line not routed");

    a_nmi_route: assert property ( // R21
        ##1 nmi_o[1] == ($past(st.core[1].nmi_sel) < 8'd147
            && $past(periph_irq_i[st.core[1].nmi_sel]))
    ) else $error("nmi not taken from selected source");

    a_wake_large: assert property ( // R15
        ##1 large_wake_o == $past(|periph_irq_i[40:0])
    ) else $error("large wake not from lines 0 to 40");

    a_wake_ipc: assert property ( // R20
        $past(|periph_irq_i[`LINE_IPC_LAST:`LINE_IPC_FIRST]) |-> large_wake_o
    ) else $error("ipc line did not wake");

    a_wake_small: assert property ( // R16
        small_wake_o |-> |small_core_irq_o[7:0]
    ) else $error("small wake without low line");

    a_sel_write: assert property ( // R24
        line_hit && we_i && sel_i[0] && adr_i[4:2] == 3'h0
        |=> st.line_sel[0] == $past(dat_i[7:0])
    ) else $error("line selector not written");

    a_nmi_sel: assert property ( // R23
        w_nmi[0] |=> st.core[0].nmi_sel == $past(dat_i[7:0])
    ) else $error("nmi selector not written");

    a_bus_ack: assert property (
        req |=> ack_o ##1 !ack_o
    ) else $error("bus answer not one cycle");

    a_defer_set_large: assert property ( // R01
        w_ctl[1] && dat_i[`DEFER_SET_BIT] |=> defer_pend_o[1]
    ) else $error("large deferred set write ignored");

    a_defer_clear_small: assert property ( // R02
        w_ctl[0] && dat_i[`DEFER_CLR_BIT] && !dat_i[`DEFER_SET_BIT] |=> !defer_pend_o[0]
    ) else $error("small deferred clear write ignored");

    a_defer_serve: assert property ( // R01
        defer_done_i[0] && !(w_ctl[0] && dat_i[`DEFER_SET_BIT]) |=> !defer_pend_o[0]
    ) else $error("deferred pending kept after service");

    a_tick_serve: assert property ( // R10
        tick_done_i[1] && !tick_hw[1] && !(w_ctl[1] && dat_i[`TICK_SET_BIT])
        |=> !tick_pend_o[1]
    ) else $error("tick pending kept after service");

    a_tick_soft_small: assert property ( // R09
        w_ctl[0] && dat_i[`TICK_SET_BIT] |=> tick_pend_o[0]
    ) else $error("small tick set write ignored");

    a_tick_masked: assert property ( // R07
        !st.core[1].tick_int && !tick_pend_o[1] && !(w_ctl[1] && dat_i[`TICK_SET_BIT])
        |=> !tick_pend_o[1]
    ) else $error("tick pending while irq enable clear");

    a_tick_raise_large: assert property ( // R06
        st.core[1].tick_en && st.core[1].tick_int && st.core[1].current == 24'h000001
        |=> tick_pend_o[1]
    ) else $error("large tick exception not raised");

    a_reload_large: assert property ( // R05
        st.core[1].tick_en && !w_cur[1] && st.core[1].current == 24'h000000
        |=> st.core[1].current == $past(st.core[1].reload)
    ) else $error("large tick counter did not reload");

    a_defer_prio_large: assert property ( // R04
        w_pri[1] && sel_i[2] |=> defer_prio_o[5:3] == $past(dat_i[`PRIO_DEFER_LSB +: 3])
    ) else $error("large deferred priority not stored");

    a_tick_prio_small: assert property ( // R08
        w_pri[0] && sel_i[3] |=> tick_prio_o[1:0] == $past(dat_i[`PRIO_TICK_LSB +: 2])
    ) else $error("small tick priority not stored");

    a_nmi_small: assert property ( // R21
        ##1 nmi_o[0] == ($past(st.core[0].nmi_sel) < 8'd147
            && $past(periph_irq_i[st.core[0].nmi_sel]))
    ) else $error("small nmi not taken from selected source");

    a_wake_high_lines: assert property ( // R22
        !(|periph_irq_i[40:0]) |=> !large_wake_o
    ) else $error("line above 40 woke the device");

    a_wake_small_high: assert property ( // R16
        small_core_irq_o[31] && !(|small_core_irq_o[7:0]) |-> !small_wake_o
    ) else $error("small core woken by a high line");

endmodule // irq_route_top

// ==== tb/irq_periph_model.sv ====
module irq_periph_model
    import irq_route_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [146:0] raise_i,
    input wire logic [146:0] wclr_i,
    input wire logic [1:0] serve_defer_i,
    input wire logic [1:0] serve_tick_i,
    output logic [146:0] periph_irq_o,
    output logic [1:0] defer_done_o,
    output logic [1:0] tick_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////
    // peripheral levels held until written clear; cores report service
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_irq_o <= '0;
            defer_done_o <= '0;
            tick_done_o <= '0;
        end else begin
            periph_irq_o <= (periph_irq_o | raise_i) & ~wclr_i;
            defer_done_o <= serve_defer_i;
            tick_done_o <= serve_tick_i;
        end
    end
endmodule // irq_periph_model

// ==== tb/testbench.sv ====
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_route_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack_o, swake, lwake;
    logic [7:0] adr, b;
    logic [3:0] sel;
    logic [31:0] wdat, dat_o, q, small_irq;
    logic [146:0] raise, wclr, periph, large_irq, lvl;
    logic [1:0] sdef, stick, ddone, tdone, nmi, dpend, tpend;
    logic [5:0] dprio, tprio;
    logic [7:0] lsel [32];
    int bad_count, cmp_count, n;
    ////////////////////////////////////////
    irq_route_top irq_route_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .periph_irq_i(periph), .defer_done_i(ddone), .tick_done_i(tdone),
        .large_core_irq_o(large_irq), .small_core_irq_o(small_irq), .nmi_o(nmi),
        .defer_pend_o(dpend), .tick_pend_o(tpend), .defer_prio_o(dprio), .tick_prio_o(tprio),
        .small_wake_o(swake), .large_wake_o(lwake));
    irq_periph_model irq_periph_model_i (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
        .wclr_i(wclr), .serve_defer_i(sdef), .serve_tick_i(stick), .periph_irq_o(periph),
        .defer_done_o(ddone), .tick_done_o(tdone));
    always #12.5 clk_i = ~clk_i;
    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        q = dat_o;
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k >= 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        wb(1'b1, a, d, s);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic wait_n(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic src(input logic [146:0] r, input logic [146:0] c);
        @(posedge clk_i);
        raise <= r;
        wclr <= c;
        @(posedge clk_i);
        raise <= '0;
        wclr <= '0;
        lvl = (lvl | r) & ~c;
        wait_n(3);
    endtask
    task automatic check_route();
        logic [31:0] es;
        logic sw;
        sw = 1'b0;
        for (int k = 0; k < 32; k++) begin
            es[k] = (lsel[k] < 8'd147) ? lvl[lsel[k]] : 1'b0;
            if (k < 8 && es[k] && lsel[k] <= 8'd40) sw = 1'b1;
        end
        `CHK(large_irq, lvl)
        `CHK(small_irq, es)
        `CHK(nmi, {lvl[40], lvl[146]})
        `CHK(lwake, |lvl[40:0])
        `CHK(swake, sw)
    endtask
    ////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc, stb, we, adr, sel, wdat} = '0;
        {raise, wclr, sdef, stick, lvl} = '0;
        foreach (lsel[k]) lsel[k] = 8'h00;
        bad_count = 0;
        cmp_count = 0;
        wait_n(8);
        rst_i <= 1'b0;
        for (int c = 0; c < 2; c++) begin
            b = 8'(c * 32);
            rd(b + 8'h04);
            `CHK(q, 32'h0)
            wr(b, 32'h1000_0000, 4'h8);
            wait_n(2);
            `CHK(dpend[c], 1'b1)
            rd(b);
            `CHK(q[28], 1'b1)
            wr(b, 32'h0800_0000, 4'h8);
            wait_n(2);
            `CHK(dpend[c], 1'b0)
            wr(b, 32'h1400_0000, 4'h8);
            @(posedge clk_i);
            sdef <= 2'(1 << c);
            stick <= 2'(1 << c);
            @(posedge clk_i);
            sdef <= 2'b00;
            stick <= 2'b00;
            wait_n(3);
            `CHK(dpend[c], 1'b0)
            `CHK(tpend[c], 1'b0)
            wr(b, 32'h0400_0000, 4'h8);
            wait_n(2);
            `CHK(tpend[c], 1'b1)
            wr(b, 32'h0200_0000, 4'h8);
            wait_n(2);
            `CHK(tpend[c], 1'b0)
            wr(b + 8'h04, 32'h0707_0000, 4'hc);
            rd(b + 8'h04);
            `CHK(q, (c ? 32'h0707_0000 : 32'h0303_0000))
            `CHK(dprio[c*3 +: 3], (c ? 3'h7 : 3'h3))
            `CHK(tprio[c*3 +: 3], (c ? 3'h7 : 3'h3))
            wr(b + 8'h0c, 32'h00ff_ffff, 4'h7);
            rd(b + 8'h0c);
            `CHK(q, 32'h00ff_ffff)
            wr(b + 8'h0c, 32'h3, 4'h7);
            wr(b + 8'h10, 32'h0, 4'hf);
            wr(b + 8'h08, 32'h1, 4'h1);
            wait_n(20);
            `CHK(tpend[c], 1'b0)
            rd(b + 8'h08);
            `CHK(q[16], 1'b1)
            rd(b + 8'h10);
            `CHK(q[23:0] <= 24'h3, 1'b1)
            wr(b + 8'h08, 32'h3, 4'h1);
            n = 0;
            while (tpend[c] !== 1'b1 && n < 30) begin
                @(posedge clk_i);
                n++;
            end
            `CHK(tpend[c], 1'b1)
            wr(b + 8'h08, 32'h0, 4'h1);
            wr(b, 32'h0200_0000, 4'h8);
            wait_n(2);
            `CHK(tpend[c], 1'b0)
        end
        wr(8'h40, {8'd200, 16'h0, 8'd146}, 4'hf);
        wr(8'h5c, {8'd40, 24'h0}, 4'h8);
        wr(8'h14, 32'd146, 4'h1);
        wr(8'h34, 32'd40, 4'h1);
        lsel[0] = 8'd146;
        lsel[3] = 8'd200;
        lsel[31] = 8'd40;
        rd(8'h40);
        `CHK(q, {8'd200, 16'h0, 8'd146})
        for (int i = 0; i < 147; i++) begin
            src(147'(1) << i, ~(147'(1) << i));
            check_route();
        end
        wr(8'h44, {8'd40, 24'h0}, 4'h8);
        lsel[7] = 8'd40;
        src(147'(1) << 40, ~(147'(1) << 40));
        check_route();
        src('0, '1);
        check_route();
        rd(8'h80);
        `CHK(q, 32'h0)
        tally_and_finish();
    end
endmodule // testbench
